// ==== pkg/ccds_defines.vh ====
// Constants for the core debug control and status block
`ifndef CCDS_DEFINES_VH
`define CCDS_DEFINES_VH

// Debug register codes
`define CCDS_DRC_CFG          5'h00
`define CCDS_DRC_XSTAT        5'h01

// Debug configuration fields
`define CCDS_CFG_SKIP_IRQ     5
`define CCDS_CFG_STEP         4
`define CCDS_CFG_RSVD_HI      3
`define CCDS_CFG_RSVD_LO      2
`define CCDS_CFG_FORCE        1
`define CCDS_CFG_SUPPRESS     0
`define CCDS_CFG_RESET        32'h0000_0000
`define CCDS_CFG_RSVD_MASK    32'h0000_000c

// Extended status layout
`define CCDS_XS_HALTED        31
`define CCDS_XS_STOPPED       30
`define CCDS_XS_COMMAND_STATUS_FIELD_HI      29
`define CCDS_XS_COMMAND_STATUS_FIELD_LO      27
`define CCDS_XS_CTRL_HI       26
`define CCDS_XS_CTRL_LO       24
`define CCDS_XS_LOW_HI        23
`define CCDS_XS_LOW_LO        0
`define CCDS_XS_BYTE_RESET    6'h00
`define CCDS_XS_LOW_RESET     24'h00_0000

// Automatic pc capture control in the low 24 bits
`define CCDS_APC_ENABLE       0
`define CCDS_APC_SEL_HI       2
`define CCDS_APC_SEL_LO       1
`define CCDS_APC_BASE_LOG2    7

// Command status encodings
`define CCDS_COMMAND_STATUS_FIELD_OK         3'h0
`define CCDS_COMMAND_STATUS_FIELD_INVALID    3'h1
`define CCDS_COMMAND_STATUS_FIELD_ILLEGAL    3'h2
`define CCDS_COMMAND_STATUS_FIELD_OVERRUN    3'h4

// Debug port command codes
`define CCDS_CMD_NOP          4'h0
`define CCDS_CMD_BYTE_READ    4'h1
`define CCDS_CMD_BYTE_WRITE   4'h2
`define CCDS_CMD_REG_READ     4'h3
`define CCDS_CMD_REG_WRITE    4'h4
`define CCDS_CMD_GO           4'h5
`define CCDS_CMD_HALT         4'h6

`endif

// ==== test/ccds_core_checker.sv ====
// Port-level assertions for the core debug block
`timescale 1ns/1ps
module ccds_core_checker
(
	input wire        ref_clk,
	input wire        rst_n,
	input wire        clk_en,
	input wire        cmd_valid,
	input wire [3:0]  cmd_code,
	input wire        cmd_ready,
	input wire        rsp_valid,
	input wire [31:0] rsp_data,
	input wire        debug_write_instruction_valid,
	input wire        debug_write_instruction_supervisor,
	input wire        debug_write_instruction_illegal,
	input wire        core_run,
	input wire        pc_capture_command
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire tk = cmd_valid && cmd_ready && clk_en;
	property p_rsp; tk |=> rsp_valid; endproperty
	a_rsp: assert property (p_rsp) else $error("no answer");
	property p_one; rsp_valid && clk_en |=> !rsp_valid; endproperty
	a_one: assert property (p_one) else $error("answer too long");
	property p_sbyte; tk && cmd_code == 4'h1 |=> rsp_data[31:8] == 24'h0
		&& rsp_data[7] == !core_run;
	endproperty
	a_sbyte: assert property (p_sbyte) else $error("status byte wrong");
	property p_zero; tk && (cmd_code == 4'h2 || cmd_code == 4'h4) |=> rsp_data == 32'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("write data echo");
	property p_ill; debug_write_instruction_valid && !debug_write_instruction_supervisor && clk_en |=> debug_write_instruction_illegal;
	endproperty
	a_ill: assert property (p_ill) else $error("user write missed");
	property p_leg; debug_write_instruction_valid && debug_write_instruction_supervisor && clk_en |=> !debug_write_instruction_illegal;
	endproperty
	a_leg: assert property (p_leg) else $error("supervisor refused");
	property p_halt; tk && cmd_code == 4'h6 |-> ##[1:3] !core_run; endproperty
	a_halt: assert property (p_halt) else $error("halt ignored");
	// Interval is at least 9 cycles
	property p_pc; pc_capture_command && clk_en |=> !pc_capture_command [*8]; endproperty
	a_pc: assert property (p_pc) else $error("capture too often");
	c_read: cover property (tk && cmd_code == 4'h3);
	c_ill: cover property (debug_write_instruction_illegal);
	c_stop: cover property ($fell(core_run));
endmodule

// ==== test/ccds_host.sv ====
// Debug host model driving the command port
`timescale 1ns/1ps
module ccds_host
(
	input wire         ref_clk,
	input wire         cmd_ready,
	input wire [31:0]  rsp_data,
	output logic        cmd_valid = 1'b0,
	output logic [3:0]  cmd_code = 4'h0,
	output logic [4:0]  cmd_dreg = 5'h00,
	output logic [31:0] cmd_wdata = 32'h0
);
	// stay keeps valid one more cycle to provoke an overrun
	task xfer(input [3:0] c, input [4:0] d, input [31:0] w, input stay, output [31:0] r);
		begin
			cmd_valid <= 1'b1;
			cmd_code <= c;
			cmd_dreg <= d;
			cmd_wdata <= w;
			@(posedge ref_clk);
			while (!cmd_ready)
				@(posedge ref_clk);
			cmd_valid <= stay;
			@(posedge ref_clk);
			r = rsp_data;
			cmd_valid <= 1'b0;
			cmd_wdata <= ~w;
			// Idle edge: the next call never re-drives a signal in this time step
			@(posedge ref_clk);
		end
	endtask
endmodule

// ==== test/core_debug_control_status_bench.sv ====
// Self-checking bench for the core debug block
`timescale 1ns/1ps
module core_debug_control_status_bench;
	logic        ref_clk, rst_n, core_retire, debug_write_instruction_valid, debug_write_instruction_supervisor, core_stopped;
	logic [31:0] r;
	wire         cmd_valid, cmd_ready, rsp_valid, debug_write_instruction_illegal, core_run, irq_mask, dbg, pcc;
	wire [3:0]   cmd_code;
	wire [4:0]   cmd_dreg;
	wire [31:0]  cmd_wdata, rsp_data;
	int          fail_count = 0, num_checks = 0, i;
	ccds_core u_dut(.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_dreg(cmd_dreg), .cmd_wdata(cmd_wdata),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.core_retire(core_retire), .core_stopped(core_stopped), .debug_write_instruction_valid(debug_write_instruction_valid),
		.debug_write_instruction_supervisor(debug_write_instruction_supervisor), .debug_write_instruction_dreg(5'h01),
		.debug_write_instruction_data(32'hff00_0abc), .debug_write_instruction_illegal(debug_write_instruction_illegal), .break_pin(1'b0),
		.core_run(core_run), .irq_mask(irq_mask), .debug_mode_out(dbg),
		.pc_capture_command(pcc));
	ccds_host u_host(.ref_clk(ref_clk), .cmd_ready(cmd_ready), .rsp_data(rsp_data),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_dreg(cmd_dreg),
		.cmd_wdata(cmd_wdata));
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task chk(input [31:0] g, input [31:0] e);
		begin
			num_checks++;
			if (g !== e)
			begin
				fail_count++;
				$display("Error t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask
	task final_report;
		begin
			$display("checks=%0d errors=%0d", num_checks, fail_count);
			if (fail_count == 0 && num_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task wr(input [3:0] c, input [4:0] d, input [31:0] w);
		u_host.xfer(c, d, w, 1'b0, r);
	endtask
	task rd(input [4:0] d, input [31:0] e);
		begin
			u_host.xfer(4'h3, d, 32'h0, 1'b0, r);
			chk(r, e);
		end
	endtask
	task rb(input [7:0] e);
		begin
			u_host.xfer(4'h1, 5'h01, 32'h0, 1'b0, r);
			chk(r[7:0], e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task retire;
		begin
			core_retire <= 1'b1;
			@(posedge ref_clk);
			core_retire <= 1'b0;
		end
	endtask
	task wd(input s);
		begin
			debug_write_instruction_supervisor <= s;
			debug_write_instruction_valid <= 1'b1;
			@(posedge ref_clk);
			debug_write_instruction_valid <= 1'b0;
			@(posedge ref_clk);
		end
	endtask
	initial
	begin
		rst_n = 1'b0;
		core_retire = 1'b0;
		debug_write_instruction_valid = 1'b0;
		debug_write_instruction_supervisor = 1'b0;
		core_stopped = 1'b0;
		cyc(4);
		rst_n <= 1'b1;
		cyc(3);
		chk(core_run, 1);
		rd(5'h01, 32'h0);
		wr(4'h4, 5'h01, 32'hff00_0001);
		rd(5'h01, 32'h0000_0001);
		wr(4'h2, 5'h01, 32'h0000_0007);
		rb(8'h07);
		rd(5'h01, 32'h0700_0001);
		i = 0;
		while (!pcc && i < 300)
		begin
			@(posedge ref_clk);
			i++;
		end
		chk(pcc, 1);
		wr(4'h4, 5'h01, 32'h0);
		wd(1'b0);
		chk(debug_write_instruction_illegal, 1);
		rd(5'h01, 32'h0700_0000);
		wd(1'b1);
		rd(5'h01, 32'h0700_0abc);
		wr(4'h4, 5'h00, 32'h0000_0032);
		rd(5'h00, 32'h0000_0032);
		cyc(2);
		chk(dbg, 1);
		chk(irq_mask, 1);
		wr(4'h4, 5'h00, 32'h0000_0010);
		cyc(2);
		chk(dbg, 0);
		chk(irq_mask, 0);
		retire;
		cyc(3);
		chk(core_run, 0);
		chk(dbg, 1);
		rb(8'h87);
		wr(4'h5, 5'h00, 32'h0);
		cyc(2);
		chk(core_run, 1);
		retire;
		cyc(3);
		chk(core_run, 0);
		wr(4'h4, 5'h00, 32'h0000_0011);
		cyc(2);
		chk(dbg, 0);
		wr(4'h4, 5'h00, 32'h0);
		wr(4'h5, 5'h00, 32'h0);
		cyc(2);
		chk(core_run, 1);
		rb(8'h07);
		wr(4'h7, 5'h00, 32'h0);
		rb(8'h17);
		wr(4'h3, 5'h05, 32'h0);
		rb(8'h0f);
		u_host.xfer(4'h1, 5'h01, 32'h0, 1'b1, r);
		rb(8'h27);
		rb(8'h07);
		core_stopped <= 1'b1;
		cyc(1);
		rb(8'h47);
		wr(4'h6, 5'h00, 32'h0);
		rb(8'h87);
		chk(core_run, 0);
		wr(4'h0, 5'h00, 32'h0);
		rd(5'h01, 32'h8700_0abc);
		core_stopped <= 1'b0;
		wr(4'h5, 5'h00, 32'h0);
		cyc(2);
		chk(core_run, 1);
		final_report;
	end
	initial
	begin
		#40000;
		fail_count++;
		final_report;
	end
endmodule
bind ccds_core ccds_core_checker u_chk(.*);

// ==== verilog/ccds_core.v ====
// Core debug control: configuration, extended status, stepping, debug output
`timescale 1ns/1ps
`include "ccds_defines.vh"
module ccds_core
#(
	parameter APC_CNT_W = 14
)
(
	input  wire        ref_clk,
	input  wire        rst_n,
	input  wire        clk_en,
	input  wire        cmd_valid,
	input  wire [3:0]  cmd_code,
	input  wire [4:0]  cmd_dreg,
	input  wire [31:0] cmd_wdata,
	output wire        cmd_ready,
	output reg         rsp_valid,
	output reg  [31:0] rsp_data,
	input  wire        core_retire,
	input  wire        core_stopped,
	input  wire        debug_write_instruction_valid,
	input  wire        debug_write_instruction_supervisor,
	input  wire [4:0]  debug_write_instruction_dreg,
	input  wire [31:0] debug_write_instruction_data,
	output reg         debug_write_instruction_illegal,
	input  wire        break_pin,
	output reg         core_run,
	output reg         irq_mask,
	output reg         debug_mode_out,
	output reg         pc_capture_command
);
	reg  [31:0] debug_configuration;
	reg  [5:0]  xs_byte_ctrl;
	reg  [23:0] xs_low;
	reg  [2:0]  command_status_field;
	reg         halted;
	reg         step_armed;
	reg         break_prev;
	reg  [APC_CNT_W-1:0] apc_count;
	wire        break_level;
	wire        cmd_take;
	wire        cmd_overrun;
	wire        debug_write_instruction_ok;
	wire        single_step_enable;
	wire        skip_irq_in_step;
	wire        force_debug_out;
	wire        halt_debug_suppress;
	wire [7:0]  debug_status_byte;
	wire [31:0] extended_debug_status;
	wire        apc_enable;
	wire [1:0]  apc_sel;
	wire        break_rise;
	wire        debug_by_force;
	wire        debug_by_halt;
	wire        next_debug_mode;

	// Interval of automatic pc capture in cycles for each selector value
	function [APC_CNT_W-1:0] apc_limit;
		input [1:0] sel;
		reg   [APC_CNT_W:0] one;
		begin
			one = {{APC_CNT_W{1'b0}}, 1'b1};
			apc_limit = one[APC_CNT_W-1:0] << (`CCDS_APC_BASE_LOG2 + 2 * sel);
		end
	endfunction

	// Configuration word with reserved bits forced clear
	function [31:0] cfg_clean;
		input [31:0] value;
		begin
			cfg_clean = value & ~`CCDS_CFG_RSVD_MASK;
		end
	endfunction

	// Register codes that exist; anything else is answered as invalid data
	function dreg_known;
		input [4:0] code;
		begin
			dreg_known = (code == `CCDS_DRC_XSTAT) || (code == `CCDS_DRC_CFG);
		end
	endfunction

	ccds_sync3 u_break_sync
	(
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.pin_in  (break_pin),
		.level   (break_level)
	);

	assign single_step_enable  = debug_configuration[`CCDS_CFG_STEP];
	assign skip_irq_in_step    = debug_configuration[`CCDS_CFG_SKIP_IRQ];
	assign force_debug_out     = debug_configuration[`CCDS_CFG_FORCE];
	assign halt_debug_suppress = debug_configuration[`CCDS_CFG_SUPPRESS];
	assign apc_enable          = xs_low[`CCDS_APC_ENABLE];
	assign apc_sel             = xs_low[`CCDS_APC_SEL_HI:`CCDS_APC_SEL_LO];

	// Status byte is built from live state, so it is valid in any mode
	assign debug_status_byte = {halted, core_stopped & ~halted,
		command_status_field, xs_byte_ctrl[2:0]};
	assign extended_debug_status = {debug_status_byte, xs_low};

	// Edge register resets low like the idle pin, so reset brings no false halt
	assign break_rise      = break_level & ~break_prev;
	// Force term wins; suppress only masks the halt term
	assign debug_by_force  = force_debug_out;
	assign debug_by_halt   = halted & ~halt_debug_suppress;
	assign next_debug_mode = debug_by_force | debug_by_halt;

	// Not ready in the cycle of every answer; a command in that cycle is an overrun
	assign cmd_ready   = ~rsp_valid;
	assign cmd_take    = cmd_valid & cmd_ready;
	assign cmd_overrun = cmd_valid & ~cmd_ready;
	assign debug_write_instruction_ok   = debug_write_instruction_valid & debug_write_instruction_supervisor;

	// Debug port command handling and status reporting
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			rsp_valid            <= 1'b0;
			rsp_data             <= 32'h0000_0000;
			command_status_field <= `CCDS_COMMAND_STATUS_FIELD_OK;
			xs_byte_ctrl         <= `CCDS_XS_BYTE_RESET;
		end
		else if (clk_en)
		begin
			rsp_valid <= cmd_take;
			if (cmd_overrun)
				command_status_field <= `CCDS_COMMAND_STATUS_FIELD_OVERRUN;
			else if (cmd_take)
			begin
				rsp_data             <= 32'h0000_0000;
				command_status_field <= `CCDS_COMMAND_STATUS_FIELD_OK;
				case (cmd_code)
					`CCDS_CMD_NOP:
					begin
						rsp_data <= 32'h0000_0000;
					end
					`CCDS_CMD_BYTE_READ:
					begin
						rsp_data <= {24'h00_0000, debug_status_byte};
					end
					`CCDS_CMD_BYTE_WRITE:
					begin
						// Only the low three bits reach the status byte; the top five are status and cannot be written
						xs_byte_ctrl <= cmd_wdata[5:0];
					end
					`CCDS_CMD_REG_READ:
					begin
						if (cmd_dreg == `CCDS_DRC_XSTAT)
							rsp_data <= extended_debug_status;
						else if (cmd_dreg == `CCDS_DRC_CFG)
							rsp_data <= debug_configuration;
						else
							command_status_field <= `CCDS_COMMAND_STATUS_FIELD_INVALID;
					end
					`CCDS_CMD_REG_WRITE:
					begin
						if (!dreg_known(cmd_dreg))
							command_status_field <= `CCDS_COMMAND_STATUS_FIELD_INVALID;
					end
					`CCDS_CMD_GO:
					begin
						if (!halted)
							command_status_field <= `CCDS_COMMAND_STATUS_FIELD_ILLEGAL;
					end
					`CCDS_CMD_HALT:
					begin
						rsp_data <= 32'h0000_0000;
					end
					default:
					begin
						command_status_field <= `CCDS_COMMAND_STATUS_FIELD_ILLEGAL;
					end
				endcase
			end
		end
	end

	// Register writes from the port and from the supervisor instruction
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			debug_configuration <= `CCDS_CFG_RESET;
			xs_low              <= `CCDS_XS_LOW_RESET;
			debug_write_instruction_illegal      <= 1'b0;
		end
		else if (clk_en)
		begin
			debug_write_instruction_illegal <= debug_write_instruction_valid & ~debug_write_instruction_supervisor;
			// Port write takes priority when both land in one cycle
			if (cmd_take && cmd_code == `CCDS_CMD_REG_WRITE)
			begin
				if (cmd_dreg == `CCDS_DRC_XSTAT)
					xs_low <= cmd_wdata[`CCDS_XS_LOW_HI:`CCDS_XS_LOW_LO];
				else if (cmd_dreg == `CCDS_DRC_CFG)
					debug_configuration <= cfg_clean(cmd_wdata);
			end
			else if (debug_write_instruction_ok)
			begin
				if (debug_write_instruction_dreg == `CCDS_DRC_XSTAT)
					xs_low <= debug_write_instruction_data[`CCDS_XS_LOW_HI:`CCDS_XS_LOW_LO];
				else if (debug_write_instruction_dreg == `CCDS_DRC_CFG)
					debug_configuration <= cfg_clean(debug_write_instruction_data);
			end
		end
	end

	// Halt and single-step sequencing
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			halted     <= 1'b0;
			step_armed <= 1'b0;
			break_prev <= 1'b0;
		end
		else if (clk_en)
		begin
			break_prev <= break_level;
			if (cmd_take && cmd_code == `CCDS_CMD_HALT)
				halted <= 1'b1;
			else if (break_rise)
				halted <= 1'b1;
			else if (halted)
			begin
				// Any command is served while halted; only go releases
				if (cmd_take && cmd_code == `CCDS_CMD_GO)
				begin
					halted     <= 1'b0;
					step_armed <= single_step_enable;
				end
			end
			else if (core_retire && (single_step_enable || step_armed))
			begin
				// Exactly one instruction per go, until stepping is cleared
				halted     <= single_step_enable;
				step_armed <= 1'b0;
			end
		end
	end

	// Core-facing outputs registered to keep them glitch free
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			core_run       <= 1'b0;
			irq_mask       <= 1'b0;
			debug_mode_out <= 1'b0;
		end
		else if (clk_en)
		begin
			core_run       <= ~halted;
			irq_mask       <= single_step_enable & skip_irq_in_step;
			debug_mode_out <= next_debug_mode;
		end
	end

	// Periodic pc capture; paused while halted since the pc does not move
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			apc_count          <= {APC_CNT_W{1'b0}};
			pc_capture_command <= 1'b0;
		end
		else if (clk_en)
		begin
			pc_capture_command <= 1'b0;
			if (!apc_enable)
				apc_count <= {APC_CNT_W{1'b0}};
			else if (!halted)
			begin
				if (apc_count >= apc_limit(apc_sel) - 1'b1)
				begin
					apc_count          <= {APC_CNT_W{1'b0}};
					pc_capture_command <= 1'b1;
				end
				else
					apc_count <= apc_count + 1'b1;
			end
		end
	end
endmodule

// ==== verilog/ccds_sync3.v ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ccds_sync3
(
	input  wire ref_clk,
	input  wire rst_n,
	input  wire clk_en,
	input  wire pin_in,
	output reg  level
);
	reg stage1;
	reg stage2;
	reg stage3;

	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
			level  <= 1'b0;
		end
		else if (clk_en)
		begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
			// Only a value held for two sampled edges is taken
			if (stage2 == stage3)
				level <= stage3;
		end
	end
endmodule
